// ---- include/ldcfg_pkg.sv ----
package ldcfg_pkg;

	// ****************************************
	// index locations
	// ****************************************
	localparam logic [7:0] idx_ldn      = 8'h07;
	localparam logic [7:0] idx_activate = 8'h30;
	localparam logic [7:0] idx_base1_hi = 8'h60;
	localparam logic [7:0] idx_base1_lo = 8'h61;
	localparam logic [7:0] idx_base2_hi = 8'h62;
	localparam logic [7:0] idx_base2_lo = 8'h63;
	localparam logic [7:0] idx_irq0     = 8'h70;
	localparam logic [7:0] idx_irq1     = 8'h72;
	localparam logic [7:0] idx_dma      = 8'h74;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic       rst_activate = 1'b0;
	localparam logic [7:0] rst_index    = 8'h00;
	localparam logic [7:0] rst_ldn      = 8'h00;
	localparam logic [7:0] rst_base     = 8'h00;
	localparam logic [7:0] rst_irq      = 8'h00;
	localparam logic [7:0] rst_dma      = 8'h04;

	// ****************************************
	// logical units and their features
	// ****************************************
	localparam int          num_units      = 16;
	localparam int          ldn_floppy     = 0;
	localparam int          ldn_parallel   = 3;
	localparam int          ldn_serial1    = 4;
	localparam int          ldn_serial2    = 5;
	localparam int          ldn_acpi       = 10;
	localparam logic [15:0] mask_exists    = 16'h05f9;
	localparam logic [15:0] mask_base1     = 16'h0439;
	localparam logic [15:0] mask_base2     = 16'h0060;
	localparam logic [15:0] mask_irq2      = 16'h0080;
	localparam logic [15:0] mask_dma       = 16'h0029;

	// chip-level power-control bit positions
	localparam int pwr_bit_floppy   = 0;
	localparam int pwr_bit_parallel = 3;
	localparam int pwr_bit_serial1  = 4;
	localparam int pwr_bit_serial2  = 5;

	// ****************************************
	// permitted primary base ranges
	// ****************************************
	localparam logic [15:0] std_base_min  = 16'h0100;
	localparam logic [15:0] std_base_max  = 16'h0ff8;
	localparam int          std_align     = 8;
	localparam logic [15:0] pp_base_max   = 16'h0ffc;
	localparam int          pp_align      = 4;
	localparam logic [15:0] acpi_base_min = 16'h0000;
	localparam logic [15:0] acpi_base_max = 16'h0fe7;
	localparam int          acpi_align    = 24;

endpackage

// ---- logic/base_range_check.sv ----
`timescale 1ns/1ps

module base_range_check #(
	parameter logic [15:0] base_min = 16'h0000,
	parameter logic [15:0] base_max = 16'hffff,
	parameter int          align    = 1
) (
	input  wire logic [15:0] base,
	output logic             in_range
);

	// the modulo is by a constant, so it folds into a small decoder
	always_comb begin
		in_range = (base >= base_min) && (base <= base_max) && ((32'(base) % align) == 0);
	end

endmodule // base_range_check

// ---- logic/unit_bank.sv ----
`timescale 1ns/1ps

module unit_bank #(
	parameter bit has_base1   = 1'b0,
	parameter bit has_base2   = 1'b0,
	parameter bit has_irq2    = 1'b0,
	parameter bit has_dma     = 1'b0,
	parameter bit standby_act = 1'b0
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        standby_reset_n,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_index,
	input  wire logic [7:0]  wr_data,
	input  wire logic        pwr_set,
	input  wire logic        pwr_val,
	output logic             act,
	output logic      [15:0] base1,
	output logic      [15:0] base2,
	output logic      [7:0]  irq0,
	output logic      [7:0]  irq1,
	output logic      [7:0]  dma
);

	logic       act_q, act_d;
	logic [7:0] b1h_q, b1h_d, b1l_q, b1l_d;
	logic [7:0] b2h_q, b2h_d, b2l_q, b2l_d;
	logic [7:0] irq0_q, irq0_d, irq1_q, irq1_d, dma_q, dma_d;
	logic       act_rst_n;

	// ****************************************
	// activate bit
	// ****************************************
	// standby-only clear
	assign act_rst_n = standby_act ? standby_reset_n : reset_n;

	always_comb begin
		act_d = act_q;
		if (wr_en && wr_index == ldcfg_pkg::idx_activate) begin
			act_d = wr_data[0];
		end else if (pwr_set) begin
			act_d = pwr_val;
		end
	end

	always_ff @(posedge core_clk or negedge act_rst_n) begin
		if (!act_rst_n) begin
			act_q <= ldcfg_pkg::rst_activate;
		end else begin
			act_q <= act_d;
		end
	end

	// ****************************************
	// base, interrupt and dma selects
	// ****************************************
	always_comb begin
		b1h_d  = b1h_q;
		b1l_d  = b1l_q;
		b2h_d  = b2h_q;
		b2l_d  = b2l_q;
		irq0_d = irq0_q;
		irq1_d = irq1_q;
		dma_d  = dma_q;
		if (wr_en) begin
			case (wr_index)
				ldcfg_pkg::idx_base1_hi: b1h_d = has_base1 ? wr_data : b1h_q;
				ldcfg_pkg::idx_base1_lo: b1l_d = has_base1 ? wr_data : b1l_q;
				ldcfg_pkg::idx_base2_hi: b2h_d = has_base2 ? wr_data : b2h_q;
				ldcfg_pkg::idx_base2_lo: b2l_d = has_base2 ? wr_data : b2l_q;
				ldcfg_pkg::idx_irq0: irq0_d = wr_data;
				ldcfg_pkg::idx_irq1: irq1_d = has_irq2 ? wr_data : irq1_q;
				ldcfg_pkg::idx_dma: dma_d = has_dma ? wr_data : dma_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			b1h_q  <= ldcfg_pkg::rst_base;
			b1l_q  <= ldcfg_pkg::rst_base;
			b2h_q  <= ldcfg_pkg::rst_base;
			b2l_q  <= ldcfg_pkg::rst_base;
			irq0_q <= ldcfg_pkg::rst_irq;
			irq1_q <= ldcfg_pkg::rst_irq;
			dma_q  <= ldcfg_pkg::rst_dma;
		end else begin
			b1h_q  <= b1h_d;
			b1l_q  <= b1l_d;
			b2h_q  <= b2h_d;
			b2l_q  <= b2l_d;
			irq0_q <= irq0_d;
			irq1_q <= irq1_d;
			dma_q  <= dma_d;
		end
	end

	assign base1 = has_base1 ? {b1h_q, b1l_q} : 16'h0000;
	assign base2 = has_base2 ? {b2h_q, b2l_q} : 16'h0000;
	assign irq0  = irq0_q;
	assign irq1  = has_irq2 ? irq1_q : 8'h00;
	assign dma   = has_dma ? dma_q : 8'h00;
	assign act   = act_q;

endmodule // unit_bank

// ---- logic/logical_device_config_bank.sv ----
`timescale 1ns/1ps

//Contract
// - writing activate bit 0 as 1 turns on the selected logical unit.
// - activate bit 0 holding 0 keeps the selected unit inactive.
// - primary base: first index gives bits 15-8, next gives 7-0.
// - second base, where needed, comes from 0x62 high then 0x63 low.
// - base registers a unit does not use ignore writes, read zero.
// - primary interrupt select exists for every unit, resets to zero.
// - secondary interrupt select only for keyboard unit; elsewhere reads zero.
// - interrupts default to edge-triggered active-high signalling.
// - dma select only for floppy, serial 2, parallel; resets to four.
// - second dma select location ignores writes and reads zero.
// - indices 0x31-0x37 and 0x40-0x5f ignore writes, read zero.
// - indices 0x38-0x3f ignore writes, read zero.
// - indices 0x71, 0x73, 0x76-0xdf ignore writes, read zero.
// - unit is active when activate bit or power-control bit set.
// - activate bit and power-control bit are linked both ways.
// - base outside permitted range makes the unit's host accesses ignored.
// - serial port 2 activate clears only on standby power-on reset.
// - logical device number register picks the visible bank.
// - bank access only in configuration state via index then data.
// - irq select zero means no line; low nibble picks level.
module logical_device_config_bank (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        standby_reset_n,
	input  wire logic        cfg_state,
	input  wire logic        host_wr,
	input  wire logic        host_rd,
	input  wire logic        host_data_sel,
	input  wire logic [7:0]  host_wdata,
	output logic      [7:0]  host_rdata,
	output logic             host_rvalid,
	input  wire logic        pwr_ctl_wr,
	input  wire logic [7:0]  pwr_ctl_wdata,
	output logic      [7:0]  pwr_ctl_rdata,
	output logic      [15:0] unit_active,
	output logic      [15:0] unit_io_enable,
	output logic      [15:0] unit_irq_enabled,
	output logic      [63:0] unit_irq_level,
	output logic      [47:0] unit_dma_channel
);

	logic [7:0]  index_q;
	logic [7:0]  index_d;
	logic [7:0]  ldn_q;
	logic [7:0]  ldn_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [7:0]  pwr_q;
	logic [7:0]  pwr_d;
	logic [15:0] active_q;
	logic [15:0] active_d;
	logic [15:0] io_en_q;
	logic [15:0] io_en_d;
	logic [15:0] irq_en_q;
	logic [15:0] irq_en_d;
	logic [63:0] irq_q;
	logic [63:0] irq_d;
	logic [47:0] dma_q;
	logic [47:0] dma_d;

	logic        idx_wr;
	logic        idx_rd;
	logic        data_wr;
	logic        data_rd;
	logic        unit_ok;
	logic [3:0]  unit;
	logic [7:0]  rd_mux;
	logic [15:0] bank_sel;
	logic [15:0] act_w;
	logic [15:0] range_ok_w;
	logic [15:0] pwr_set_w;
	logic [15:0] pwr_val_w;
	logic [15:0] base1_w [16];
	logic [15:0] base2_w [16];
	logic [7:0]  irq0_w [16];
	logic [7:0]  irq1_w [16];
	logic [7:0]  dma_w [16];

	// ****************************************
	// host port decode
	// ****************************************
	// config state gate
	// outside configuration state the ports look dead, so a stray bus cycle cannot disturb a running unit
	always_comb begin
		idx_wr  = 1'b0;
		idx_rd  = 1'b0;
		data_wr = 1'b0;
		data_rd = 1'b0;
		if (cfg_state) begin
			idx_wr  = host_wr & ~host_data_sel;
			idx_rd  = host_rd & ~host_data_sel;
			data_wr = host_wr & host_data_sel;
			data_rd = host_rd & host_data_sel;
		end
	end

	assign unit    = ldn_q[3:0];
	assign unit_ok = (ldn_q[7:4] == 4'h0) && ldcfg_pkg::mask_exists[unit];

	// bank writes only for indices 0x30 and up; lower ones are chip level
	always_comb begin
		bank_sel = 16'h0000;
		if (unit_ok && index_q >= ldcfg_pkg::idx_activate) begin
			bank_sel[unit] = 1'b1;
		end
	end

	// ****************************************
	// per-unit banks
	// ****************************************
	for (genvar g = 0; g < ldcfg_pkg::num_units; g++) begin : g_unit
		localparam bit has_pwr = (g == ldcfg_pkg::ldn_floppy) || (g == ldcfg_pkg::ldn_parallel) ||
			(g == ldcfg_pkg::ldn_serial1) || (g == ldcfg_pkg::ldn_serial2);
		localparam int pwr_pos = (g == ldcfg_pkg::ldn_parallel) ? ldcfg_pkg::pwr_bit_parallel :
			(g == ldcfg_pkg::ldn_serial1) ? ldcfg_pkg::pwr_bit_serial1 :
			(g == ldcfg_pkg::ldn_serial2) ? ldcfg_pkg::pwr_bit_serial2 : ldcfg_pkg::pwr_bit_floppy;

		if (has_pwr) begin : g_pwr
			assign pwr_set_w[g] = pwr_ctl_wr;
			assign pwr_val_w[g] = pwr_ctl_wdata[pwr_pos];
		end else begin : g_nopwr
			assign pwr_set_w[g] = 1'b0;
			assign pwr_val_w[g] = 1'b0;
		end

		if (ldcfg_pkg::mask_exists[g]) begin : g_bank
			unit_bank #(
				.has_base1   (ldcfg_pkg::mask_base1[g]),
				.has_base2   (ldcfg_pkg::mask_base2[g]),
				.has_irq2    (ldcfg_pkg::mask_irq2[g]),
				.has_dma     (ldcfg_pkg::mask_dma[g]),
				.standby_act (g == ldcfg_pkg::ldn_serial2)
			) u_bank (
				.core_clk        (core_clk),
				.reset_n         (reset_n),
				.standby_reset_n (standby_reset_n),
				.wr_en           (data_wr & bank_sel[g]),
				.wr_index        (index_q),
				.wr_data         (host_wdata),
				.pwr_set         (pwr_set_w[g]),
				.pwr_val         (pwr_val_w[g]),
				.act             (act_w[g]),
				.base1           (base1_w[g]),
				.base2           (base2_w[g]),
				.irq0            (irq0_w[g]),
				.irq1            (irq1_w[g]),
				.dma             (dma_w[g])
			);
		end else begin : g_empty
			assign act_w[g]   = 1'b0;
			assign base1_w[g] = 16'h0000;
			assign base2_w[g] = 16'h0000;
			assign irq0_w[g]  = 8'h00;
			assign irq1_w[g]  = 8'h00;
			assign dma_w[g]   = 8'h00;
		end

		// base range check
		// the parallel unit takes the looser four-byte window; its eight-byte modes are its own concern
		if (ldcfg_pkg::mask_base1[g]) begin : g_range
			localparam logic [15:0] rng_min   = (g == ldcfg_pkg::ldn_acpi) ? ldcfg_pkg::acpi_base_min :
				ldcfg_pkg::std_base_min;
			localparam logic [15:0] rng_max   = (g == ldcfg_pkg::ldn_acpi) ? ldcfg_pkg::acpi_base_max :
				(g == ldcfg_pkg::ldn_parallel) ? ldcfg_pkg::pp_base_max :
				ldcfg_pkg::std_base_max;
			localparam int          rng_align = (g == ldcfg_pkg::ldn_acpi) ? ldcfg_pkg::acpi_align :
				(g == ldcfg_pkg::ldn_parallel) ? ldcfg_pkg::pp_align :
				ldcfg_pkg::std_align;

			base_range_check #(
				.base_min (rng_min),
				.base_max (rng_max),
				.align    (rng_align)
			) u_range (
				.base     (base1_w[g]),
				.in_range (range_ok_w[g])
			);
		end else begin : g_fixed
			// units at fixed addresses have nothing to misprogram
			assign range_ok_w[g] = 1'b1;
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rd_mux = 8'h00;
		case (index_q)
			ldcfg_pkg::idx_ldn: rd_mux = ldn_q;
			ldcfg_pkg::idx_activate: rd_mux = {7'h00, act_w[unit]};
			ldcfg_pkg::idx_base1_hi: rd_mux = base1_w[unit][15:8];
			ldcfg_pkg::idx_base1_lo: rd_mux = base1_w[unit][7:0];
			ldcfg_pkg::idx_base2_hi: rd_mux = base2_w[unit][15:8];
			ldcfg_pkg::idx_base2_lo: rd_mux = base2_w[unit][7:0];
			ldcfg_pkg::idx_irq0: rd_mux = irq0_w[unit];
			ldcfg_pkg::idx_irq1: rd_mux = irq1_w[unit];
			ldcfg_pkg::idx_dma: rd_mux = dma_w[unit];
			default: rd_mux = 8'h00;
		endcase
		// an absent unit answers zero everywhere above the chip-level block
		if (!unit_ok && index_q != ldcfg_pkg::idx_ldn) begin
			rd_mux = 8'h00;
		end
	end

	// ****************************************
	// host port registers
	// ****************************************
	always_comb begin
		index_d = index_q;
		if (idx_wr) begin
			index_d = host_wdata;
		end
		// the number is kept even when it names an absent unit, so the host can read back its mistake
		ldn_d = ldn_q;
		if (data_wr && index_q == ldcfg_pkg::idx_ldn) begin
			ldn_d = host_wdata;
		end
		rvalid_d = idx_rd | data_rd;
		// read data holds between reads so a slow host may sample late
		rdata_d  = rdata_q;
		if (idx_rd) begin
			rdata_d = index_q;
		end else if (data_rd) begin
			rdata_d = rd_mux;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			index_q  <= ldcfg_pkg::rst_index;
			ldn_q    <= ldcfg_pkg::rst_ldn;
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			index_q  <= index_d;
			ldn_q    <= ldn_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ****************************************
	// unit view registers
	// ****************************************
	// every view lags the bank by one edge, so all of them move together
	always_comb begin
		pwr_d = 8'h00;
		pwr_d[ldcfg_pkg::pwr_bit_floppy]   = act_w[ldcfg_pkg::ldn_floppy];
		pwr_d[ldcfg_pkg::pwr_bit_parallel] = act_w[ldcfg_pkg::ldn_parallel];
		pwr_d[ldcfg_pkg::pwr_bit_serial1]  = act_w[ldcfg_pkg::ldn_serial1];
		pwr_d[ldcfg_pkg::pwr_bit_serial2]  = act_w[ldcfg_pkg::ldn_serial2];
		active_d = act_w;
		io_en_d = act_w & range_ok_w;
		for (int i = 0; i < ldcfg_pkg::num_units; i++) begin
			irq_d[i*4 +: 4] = irq0_w[i][3:0];
			irq_en_d[i]     = act_w[i] & (irq0_w[i][3:0] != 4'h0);
			dma_d[i*3 +: 3] = dma_w[i][2:0];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pwr_q    <= 8'h00;
			active_q <= 16'h0000;
			io_en_q  <= 16'h0000;
			irq_en_q <= 16'h0000;
			irq_q    <= 64'h0000_0000_0000_0000;
			dma_q    <= 48'h0000_0000_0000;
		end else begin
			pwr_q    <= pwr_d;
			active_q <= active_d;
			io_en_q  <= io_en_d;
			irq_en_q <= irq_en_d;
			irq_q    <= irq_d;
			dma_q    <= dma_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign host_rdata       = rdata_q;
	assign host_rvalid      = rvalid_q;
	assign pwr_ctl_rdata    = pwr_q;
	assign unit_active      = active_q;
	assign unit_io_enable   = io_en_q;
	assign unit_irq_enabled = irq_en_q;
	assign unit_irq_level   = irq_q;
	assign unit_dma_channel = dma_q;

endmodule // logical_device_config_bank

// ---- dv/ldcfg_monitor.sv ----
`timescale 1ns/1ps

module ldcfg_monitor (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        standby_reset_n,
	input wire logic        cfg_state,
	input wire logic        host_wr,
	input wire logic        host_rd,
	input wire logic        host_data_sel,
	input wire logic [7:0]  host_wdata,
	input wire logic [7:0]  host_rdata,
	input wire logic        host_rvalid,
	input wire logic        pwr_ctl_wr,
	input wire logic [7:0]  pwr_ctl_wdata,
	input wire logic [7:0]  pwr_ctl_rdata,
	input wire logic [15:0] unit_active,
	input wire logic [15:0] unit_irq_enabled,
	input wire logic [63:0] unit_irq_level
);
	logic [7:0]  idx_q;
	logic [7:0]  idx_d;
	logic [7:0]  ldn_q;
	logic [7:0]  ldn_d;
	logic [15:0] nz;

	// shadow of index and unit number, so data reads can be judged
	always_comb begin
		idx_d = idx_q;
		ldn_d = ldn_q;
		if (cfg_state && host_wr && !host_data_sel)
			idx_d = host_wdata;
		if (cfg_state && host_wr && host_data_sel && idx_q == ldcfg_pkg::idx_ldn)
			ldn_d = host_wdata;
		for (int i = 0; i < 16; i++)
			nz[i] = |unit_irq_level[4*i +: 4];
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_q <= 8'h00;
			ldn_q <= 8'h00;
		end else begin
			idx_q <= idx_d;
			ldn_q <= ldn_d;
		end
	end

	function automatic logic rsv(input logic [7:0] i);
		return (i >= 8'h31 && i <= 8'h5f) || i == 8'h71 || i == 8'h73 || (i >= 8'h75 && i <= 8'hdf);
	endfunction

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence rd_taken;
		cfg_state && host_rd;
	endsequence
	sequence act_wr;
		cfg_state && host_wr && host_data_sel && idx_q == ldcfg_pkg::idx_activate && ldn_q < 8'h10
			&& ldcfg_pkg::mask_exists[ldn_q[3:0]];
	endsequence

	rvalid_follows_a: assert property (rd_taken |=> host_rvalid)
		else $error("no read valid after read");
	rvalid_only_a: assert property (!(cfg_state && host_rd) |=> !host_rvalid)
		else $error("read valid without read");
	index_readback_a: assert property (rd_taken ##0 !host_data_sel |=> host_rdata == $past(idx_q))
		else $error("index read wrong");
	reserved_zero_a: assert property (rd_taken ##0 (host_data_sel && rsv(idx_q)) |=> host_rdata == 8'h00)
		else $error("reserved read not zero");
	activate_applied_a: assert property (act_wr |-> ##2 unit_active[$past(ldn_q[3:0], 2)] == $past(host_wdata[0], 2))
		else $error("activate write not applied");
	pwr_applied_a: assert property (pwr_ctl_wr && !host_wr |-> ##2 pwr_ctl_rdata == ($past(pwr_ctl_wdata, 2) & 8'h39))
		else $error("power write not applied");
	pwr_stable_a: assert property ((!pwr_ctl_wr && !host_wr) ##0 standby_reset_n[*3] |-> $stable(pwr_ctl_rdata))
		else $error("power bits changed without write");
	active_mirror_a: assert property ({unit_active[5:3], unit_active[0]} == {pwr_ctl_rdata[5:3], pwr_ctl_rdata[0]}
		&& {pwr_ctl_rdata[7:6], pwr_ctl_rdata[2:1]} == 4'h0)
		else $error("active and power bits differ");
	irq_enable_a: assert property (unit_irq_enabled == (unit_active & nz))
		else $error("irq enable wrong");
endmodule // ldcfg_monitor

bind logical_device_config_bank ldcfg_monitor mon (.core_clk, .reset_n, .standby_reset_n, .cfg_state, .host_wr,
	.host_rd, .host_data_sel, .host_wdata, .host_rdata, .host_rvalid, .pwr_ctl_wr, .pwr_ctl_wdata, .pwr_ctl_rdata,
	.unit_active, .unit_irq_enabled, .unit_irq_level);

// ---- dv/host_model.sv ----
`timescale 1ns/1ps

module host_model (
	input wire logic  core_clk,
	output logic      cfg_state,
	output logic      host_wr,
	output logic      host_rd,
	output logic      host_data_sel,
	output logic [7:0] host_wdata
);
	initial begin
		cfg_state = 1'b1;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_data_sel = 1'b0;
		host_wdata = 8'h00;
	end

	// one port cycle; data is scrambled once released so stale values never look valid
	task automatic xfer(input logic w, input logic sel, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		host_wr = w;
		host_rd = !w;
		host_data_sel = sel;
		host_wdata = d;
		@(posedge core_clk);
		#1;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = ~d;
	endtask

	task automatic cfg(input logic on);
		@(posedge core_clk);
		#1;
		cfg_state = on;
	endtask

	task automatic activate(input logic on);
		xfer(1'b1, 1'b0, 8'h30);
		xfer(1'b1, 1'b1, {7'h00, on});
	endtask
endmodule // host_model

// ---- dv/logical_device_config_bank_bench.sv ----
`timescale 1ns/1ps

module logical_device_config_bank_bench;
	logic core_clk, reset_n, standby_reset_n, cfg_state, host_wr, host_rd, host_data_sel;
	logic host_rvalid, pwr_ctl_wr;
	logic [7:0] host_wdata, host_rdata, pwr_ctl_wdata, pwr_ctl_rdata;
	logic [15:0] unit_active, unit_io_enable, unit_irq_enabled;
	logic [63:0] unit_irq_level;
	logic [47:0] unit_dma_channel;
	int num_errors = 0;
	int num_checks = 0;
	integer seed = 32'heab8f46a;
	int n;
	logic [7:0] exp_q[$];
	logic [7:0] w[8];
	logic [7:0] prev;
	logic [31:0] r;
	int ldns[8] = '{0, 3, 4, 5, 6, 7, 8, 10};
	logic [7:0] idx[8] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h72, 8'h74, 8'h75};
	logic [15:0] msk[8] = '{ldcfg_pkg::mask_base1, ldcfg_pkg::mask_base1, ldcfg_pkg::mask_base2,
		ldcfg_pkg::mask_base2, 16'hffff, ldcfg_pkg::mask_irq2, ldcfg_pkg::mask_dma, 16'h0000};
	logic [7:0] rsv[12] = '{8'h31, 8'h37, 8'h38, 8'h3f, 8'h40, 8'h5f, 8'h71, 8'h73, 8'h76, 8'ha8, 8'ha9, 8'hdf};

	host_model host (.core_clk, .cfg_state, .host_wr, .host_rd, .host_data_sel, .host_wdata);
	logical_device_config_bank dut (.core_clk, .reset_n, .standby_reset_n, .cfg_state, .host_wr, .host_rd,
		.host_data_sel, .host_wdata, .host_rdata, .host_rvalid, .pwr_ctl_wr, .pwr_ctl_wdata, .pwr_ctl_rdata,
		.unit_active, .unit_io_enable, .unit_irq_enabled, .unit_irq_level, .unit_dma_channel);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		host.xfer(1'b1, 1'b0, i);
		host.xfer(1'b1, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		host.xfer(1'b1, 1'b0, i);
		exp_q.push_back(e);
		host.xfer(1'b0, 1'b1, 8'h00);
	endtask

	task automatic pwr(input logic [7:0] d);
		@(posedge core_clk);
		#1;
		pwr_ctl_wr = 1'b1;
		pwr_ctl_wdata = d;
		@(posedge core_clk);
		#1;
		pwr_ctl_wr = 1'b0;
		pwr_ctl_wdata = ~d;
		settle();
	endtask

	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// every read answer is matched against the oldest note, mid-cycle while the pulse stands
	always @(negedge core_clk) begin
		if (host_rvalid === 1'b1) begin
			if (exp_q.size() == 0)
				chk("unexpected read", 16'h0, 16'h1);
			else
				chk("read data", {8'h00, exp_q.pop_front()}, {8'h00, host_rdata});
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		results();
	end

	initial begin
		reset_n = 1'b0;
		standby_reset_n = 1'b0;
		pwr_ctl_wr = 1'b0;
		pwr_ctl_wdata = 8'h00;
		repeat (8) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		standby_reset_n = 1'b1;
		foreach (ldns[k]) begin
			n = ldns[k];
			wr(8'h07, n[7:0]);
			rd(8'h30, 8'h00);
			rd(8'h70, 8'h00);
			rd(8'h74, ldcfg_pkg::mask_dma[n] ? 8'h04 : 8'h00);
			foreach (idx[j]) begin
				w[j] = 8'($random(seed));
				wr(idx[j], w[j]);
			end
			foreach (idx[j])
				rd(idx[j], msk[j][n] ? w[j] : 8'h00);
			settle();
			chk("irq level", {12'h0, w[4][3:0]}, {12'h0, unit_irq_level[4*n +: 4]});
			chk("dma channel", ldcfg_pkg::mask_dma[n] ? {13'h0, w[6][2:0]} : 16'h0, {13'h0, unit_dma_channel[3*n +: 3]});
		end
		foreach (rsv[j]) begin
			wr(rsv[j], 8'($random(seed)));
			rd(rsv[j], 8'h00);
		end
		host.xfer(1'b1, 1'b0, 8'h61);
		exp_q.push_back(8'h61);
		host.xfer(1'b0, 1'b0, 8'h00);
		wr(8'h07, 8'h04);
		wr(8'h60, 8'h03);
		wr(8'h61, 8'hf8);
		wr(8'h70, 8'h05);
		host.activate(1'b1);
		settle();
		chk("active", 16'h0010, unit_active);
		chk("power view", 16'h0010, {8'h00, pwr_ctl_rdata});
		chk("io enable", 16'h0010, unit_io_enable);
		chk("irq enabled", 16'h0010, unit_irq_enabled);
		wr(8'h61, 8'h50);
		wr(8'h60, 8'h00);
		settle();
		chk("io enable off range", 16'h0000, unit_io_enable);
		host.activate(1'b0);
		settle();
		chk("inactive", 16'h0000, unit_active);
		pwr(8'hff);
		chk("power on", 16'h0039, unit_active);
		wr(8'h07, 8'h03);
		rd(8'h30, 8'h01);
		pwr(8'h00);
		rd(8'h30, 8'h00);
		host.cfg(1'b0);
		host.activate(1'b1);
		host.xfer(1'b0, 1'b1, 8'h00);
		host.cfg(1'b1);
		settle();
		chk("outside config", 16'h0000, unit_active);
		wr(8'h70, 8'h00);
		prev = 8'h00;
		repeat (8) begin
			r = $random(seed);
			host.cfg(r[0]);
			wr(8'h70, r[15:8]);
			host.cfg(1'b1);
			if (r[0])
				prev = r[15:8];
			rd(8'h70, prev);
			exp_q.push_back(r[1] ? prev : 8'h70);
			host.xfer(1'b0, r[1], 8'h00);
		end
		wr(8'h07, 8'h05);
		host.activate(1'b1);
		settle();
		@(posedge core_clk);
		#1;
		reset_n = 1'b0;
		settle();
		reset_n = 1'b1;
		settle();
		chk("standby keeps", 16'h0020, unit_active);
		standby_reset_n = 1'b0;
		settle();
		standby_reset_n = 1'b1;
		settle();
		chk("standby clears", 16'h0000, unit_active);
		chk("pending reads", 16'h0000, 16'(exp_q.size()));
		results();
	end
endmodule // logical_device_config_bank_bench
